// ===== core/conv_regs_pkg.sv
/*
  Constants for the converter configuration and status register bank:
  register addresses, field positions, write masks, reset values,
  enable and mode encodings and timing counts.
  Assumes a 250 MHz core clock.
*/
package conv_regs_pkg;
  // Register addresses
  localparam logic [7:0] ADDR_MISC = 8'h01;
  localparam logic [7:0] ADDR_FLOOR = 8'h02;
  localparam logic [7:0] ADDR_ROOF = 8'h03;
  localparam logic [7:0] ADDR_LIMIT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h05;
  localparam logic [7:0] ADDR_NVM = 8'hff;
  localparam logic [7:0] READ_NONE = 8'h00;
  // misc_config fields
  localparam int SOFT_RESET_BIT = 7;
  localparam int ENABLE_LSB = 5;
  localparam int MISC_RSVD_BIT = 4;
  localparam int PIN_ROLE_BIT = 3;
  localparam int SPREAD_BIT = 2;
  localparam int BOOST_ACTIVE_LSB = 0;
  // current_limit_config fields
  localparam int LIMIT_OFF_BIT = 5;
  localparam int SOFT_START_BIT = 4;
  localparam int VALLEY_LSB = 0;
  // nvm_control fields
  localparam int NVM_WEN_BIT = 7;
  localparam int NVM_WP_BIT = 6;
  // status_flags fields
  localparam int ST_THERMAL = 7;
  localparam int ST_HOT = 6;
  localparam int ST_PFM = 5;
  localparam int ST_BOOST = 4;
  localparam int ST_BYPASS_LIM = 3;
  localparam int ST_BOOST_LIM = 2;
  localparam int ST_FAULT = 1;
  localparam int ST_RANGE = 0;
  // Writable bits; others are dropped on write and read as zero, except nvm_control bit 5, which reads nvm_locked_status
  localparam logic [7:0] MISC_WMASK = 8'h6f;
  localparam logic [7:0] THR_WMASK = 8'h1f;
  localparam logic [7:0] LIMIT_WMASK = 8'h3f;
  localparam logic [7:0] NVM_WMASK = 8'hc0;
  // Reset values
  localparam logic [7:0] MISC_RESET = 8'h01;
  localparam logic [7:0] FLOOR_RESET = 8'h06;
  localparam logic [7:0] ROOF_RESET = 8'h06;
  localparam logic [7:0] LIMIT_RESET = 8'h1b;
  localparam logic [7:0] NVM_RESET = 8'h00;
  // Enable field and operating mode codes
  typedef enum logic [1:0] {EN_PINS = 2'h0, EN_AUTO = 2'h1, EN_PASS = 2'h2, EN_OFF = 2'h3} enable_t;
  typedef enum logic [1:0] {OM_PIN = 2'h0, OM_PFM = 2'h1, OM_PWM = 2'h2, OM_VOLTAGE_SELECT_PIN = 2'h3} boost_active_t;
  // Clear-on-read flags inside the capture module
  localparam int FLAG_COUNT = 4;
  localparam int FL_THERMAL = 0;
  localparam int FL_BYPASS = 1;
  localparam int FL_BOOST = 2;
  localparam int FL_FAULT = 3;
  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int BOOST_LIMIT_US = 1500;
  localparam int BOOST_LIMIT_CYCLES = BOOST_LIMIT_US * 1000000 / CLK_PERIOD_PS;
  localparam int POWER_OFF_NS = 1000;
  localparam int POWER_OFF_CYCLES = (POWER_OFF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage

// ===== core/flag_if.sv
/*
  Carrier between the register bank and its clear-on-read flag store.
  Assumes both ends run on the same core clock.
*/
`timescale 1ns/100ps
interface flag_if;
  logic [conv_regs_pkg::FLAG_COUNT-1:0] event_set;
  logic clear_all;
  logic wipe;
  logic [conv_regs_pkg::FLAG_COUNT-1:0] flags;
  modport bank (output event_set, output clear_all, output wipe, input flags);
  modport store (input event_set, input clear_all, input wipe, output flags);
endinterface

// ===== core/sync_bank.sv
/*
  Two-stage synchroniser for a bus of independent level signals.
  Assumes each bit is a slow level from outside the core clock domain.
*/
`timescale 1ns/100ps
module sync_bank #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Levels
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ===== core/flag_capture.sv
/*
  Sticky flags that clear when the status register is read.
  Assumes clear_all is a one-cycle read strobe; a set in that cycle wins.
*/
`timescale 1ns/100ps
module flag_capture (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Flag traffic
  flag_if.store fl
);
  genvar i;
  generate
    for (i = 0; i < conv_regs_pkg::FLAG_COUNT; i++)
    begin : g_flag
      logic flag_q;
      always_ff @(posedge core_clk or negedge rst_n)
      begin
        if (!rst_n)
          flag_q <= 1'b0;
        else if (fl.event_set[i])
          flag_q <= 1'b1;
        else if (fl.clear_all || fl.wipe)
          flag_q <= 1'b0;
      end
      assign fl.flags[i] = flag_q;
    end
  endgenerate
endmodule

// ===== core/converter_config_status_regs.sv
/*
  Configuration and status register bank of a battery front-end
  boost / pass-through converter. Serial protocol engine, non-volatile
  store and analog loop sit outside and connect through plain ports.
  Assumes reg_wr pulses once at the falling edge of the data acknowledge.
*/
`timescale 1ns/100ps
module converter_config_status_regs #(
  parameter int BOOST_LIMIT_CYCLES = conv_regs_pkg::BOOST_LIMIT_CYCLES,
  parameter logic PIN_ROLE_RESET = 1'b0
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port from the serial engine
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Device pins
  input wire logic enable_pin,
  input wire logic bypass_pin_n,
  input wire logic voltage_select_pin,
  input wire logic gpio_pin_i,
  output logic fault_irq_pin_n_o,
  output logic fault_irq_pin_n_oe,
  // Analog status
  input wire logic thermal_trip,
  input wire logic die_hot,
  input wire logic pfm_state,
  input wire logic boost_state,
  input wire logic bypass_limit_hit,
  input wire logic avg_limit_hit,
  input wire logic output_ok,
  input wire logic fault_event,
  // Non-volatile store
  input wire logic nvm_write_done,
  input wire logic nvm_locked_status,
  output logic nvm_write_req,
  output logic nvm_protect_req,
  // Converter control
  output logic converter_on,
  output logic pass_through_force,
  output logic auto_transition,
  output logic shutdown_min,
  output logic pwm_force,
  output logic spread_spectrum_on,
  output logic [4:0] changeover_code,
  output logic current_limit_disable,
  output logic soft_start_low,
  output logic [3:0] valley_limit_code
);
  typedef enum logic [1:0] {ST_RUN = 2'b01, ST_OFF = 2'b10} power_state_t;
  localparam int SYNC_W = 11;
  localparam int CYC_W = 20;
  localparam logic [CYC_W-1:0] OFF_LAST = CYC_W'(conv_regs_pkg::POWER_OFF_CYCLES - 1);
  localparam logic [CYC_W-1:0] BOOST_LAST = CYC_W'(BOOST_LIMIT_CYCLES - 1);
  localparam logic [7:0] MISC_DEFAULT = conv_regs_pkg::MISC_RESET
    | (8'(PIN_ROLE_RESET) << conv_regs_pkg::PIN_ROLE_BIT);

  logic [7:0] misc_q;
  logic [7:0] floor_q;
  logic [7:0] roof_q;
  logic [7:0] limit_q;
  logic [7:0] nvm_q;
  logic [SYNC_W-1:0] pins_async;
  logic [SYNC_W-1:0] pins_s;
  logic en_s, byp_n_s, voltage_select_pin_s, gpio_s, therm_s, hot_s, pfm_s, boost_s;
  logic byp_lim_s, avg_lim_s, ok_s;
  logic gpio_prev_q;
  logic manual_reset;
  logic soft_reset;
  power_state_t power_q;
  logic [CYC_W-1:0] off_cnt_q;
  logic [CYC_W-1:0] avg_cnt_q;
  logic boost_limit_event;
  logic status_read;
  logic [7:0] status_word;
  logic on_d, pass_d, auto_d, shut_d, pwm_d;
  flag_if fl ();

  // Write that lands on a given register
  function automatic logic hit(input logic wr, input logic [7:0] a, input logic [7:0] t);
    hit = wr && (a == t);
  endfunction

  // Synchronise every pin and analog level except fault_event, which sets the fault flag unsynchronised
  assign pins_async = {enable_pin, bypass_pin_n, voltage_select_pin, gpio_pin_i, thermal_trip,
    die_hot, pfm_state, boost_state, bypass_limit_hit, avg_limit_hit, output_ok};
  sync_bank #(.WIDTH(SYNC_W)) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pins_async),
    .sync_out(pins_s)
  );
  assign {en_s, byp_n_s, voltage_select_pin_s, gpio_s, therm_s, hot_s, pfm_s, boost_s, byp_lim_s, avg_lim_s,
    ok_s} = pins_s;

  // Manual reset: falling edge of the pin while it serves that role
  // Starts at the synchroniser's reset level so no false edge follows reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      gpio_prev_q <= 1'b0;
    else
      gpio_prev_q <= gpio_s;
  end
  assign manual_reset = !misc_q[conv_regs_pkg::PIN_ROLE_BIT] && gpio_prev_q && !gpio_s;
  assign soft_reset = (hit(reg_wr, reg_addr, conv_regs_pkg::ADDR_MISC)
    && reg_wdata[conv_regs_pkg::SOFT_RESET_BIT]) || manual_reset;

  // Configuration registers; writes land on the acknowledge strobe
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      misc_q <= MISC_DEFAULT;
      floor_q <= conv_regs_pkg::FLOOR_RESET;
      roof_q <= conv_regs_pkg::ROOF_RESET;
      limit_q <= conv_regs_pkg::LIMIT_RESET;
    end
    else if (soft_reset)
    begin
      misc_q <= MISC_DEFAULT;
      floor_q <= conv_regs_pkg::FLOOR_RESET;
      roof_q <= conv_regs_pkg::ROOF_RESET;
      limit_q <= conv_regs_pkg::LIMIT_RESET;
    end
    else
    begin
      if (hit(reg_wr, reg_addr, conv_regs_pkg::ADDR_MISC))
        misc_q <= reg_wdata & conv_regs_pkg::MISC_WMASK;
      if (hit(reg_wr, reg_addr, conv_regs_pkg::ADDR_FLOOR))
        floor_q <= reg_wdata & conv_regs_pkg::THR_WMASK;
      if (hit(reg_wr, reg_addr, conv_regs_pkg::ADDR_ROOF))
        roof_q <= reg_wdata & conv_regs_pkg::THR_WMASK;
      if (hit(reg_wr, reg_addr, conv_regs_pkg::ADDR_LIMIT))
        limit_q <= reg_wdata & conv_regs_pkg::LIMIT_WMASK;
    end
  end

  // Non-volatile control: write enable clears itself when the copy ends
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      nvm_q <= conv_regs_pkg::NVM_RESET;
    else if (soft_reset)
      nvm_q <= conv_regs_pkg::NVM_RESET;
    else if (hit(reg_wr, reg_addr, conv_regs_pkg::ADDR_NVM))
      nvm_q <= reg_wdata & conv_regs_pkg::NVM_WMASK;
    else if (nvm_write_done)
      nvm_q[conv_regs_pkg::NVM_WEN_BIT] <= 1'b0;
  end
  assign nvm_write_req = nvm_q[conv_regs_pkg::NVM_WEN_BIT];
  assign nvm_protect_req = nvm_q[conv_regs_pkg::NVM_WP_BIT];

  // Power cycle after a soft reset
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      power_q <= ST_RUN;
      off_cnt_q <= '0;
    end
    else
    begin
      case (power_q)
        ST_RUN:
        begin
          off_cnt_q <= '0;
          if (soft_reset)
            power_q <= ST_OFF;
        end
        ST_OFF:
        begin
          if (soft_reset)
            off_cnt_q <= '0;
          else if (off_cnt_q == OFF_LAST)
            power_q <= ST_RUN;
          else
            off_cnt_q <= off_cnt_q + 1'b1;
        end
        default:
          power_q <= ST_RUN;
      endcase
    end
  end

  // Enable field decode
  always_comb
  begin
    on_d = 1'b0;
    pass_d = 1'b0;
    auto_d = 1'b0;
    shut_d = 1'b0;
    case (conv_regs_pkg::enable_t'(misc_q[conv_regs_pkg::ENABLE_LSB +: 2]))
      conv_regs_pkg::EN_PINS:
      begin
        on_d = en_s;
        pass_d = en_s && !byp_n_s;
        auto_d = en_s && byp_n_s;
        shut_d = !en_s;
      end
      conv_regs_pkg::EN_AUTO:
      begin
        on_d = 1'b1;
        auto_d = 1'b1;
      end
      conv_regs_pkg::EN_PASS:
      begin
        on_d = 1'b1;
        pass_d = 1'b1;
      end
      conv_regs_pkg::EN_OFF:
        shut_d = 1'b1;
      default:
        shut_d = 1'b1;
    endcase
    if (power_q != ST_RUN)
    begin
      on_d = 1'b0;
      pass_d = 1'b0;
      auto_d = 1'b0;
      shut_d = 1'b1;
    end
  end

  // Operating mode decode; pin input counts only in the mode role
  always_comb
  begin
    case (conv_regs_pkg::boost_active_t'(misc_q[conv_regs_pkg::BOOST_ACTIVE_LSB +: 2]))
      conv_regs_pkg::OM_PIN:
        pwm_d = misc_q[conv_regs_pkg::PIN_ROLE_BIT] && gpio_s;
      conv_regs_pkg::OM_PFM:
        pwm_d = 1'b0;
      conv_regs_pkg::OM_PWM:
        pwm_d = 1'b1;
      conv_regs_pkg::OM_VOLTAGE_SELECT_PIN:
        pwm_d = voltage_select_pin_s;
      default:
        pwm_d = 1'b0;
    endcase
  end

  // Registered controls to the analog side
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      converter_on <= 1'b0;
      pass_through_force <= 1'b0;
      auto_transition <= 1'b0;
      shutdown_min <= 1'b1;
      pwm_force <= 1'b0;
      spread_spectrum_on <= 1'b0;
      changeover_code <= '0;
      current_limit_disable <= 1'b0;
      soft_start_low <= 1'b0;
      valley_limit_code <= '0;
    end
    else
    begin
      converter_on <= on_d;
      pass_through_force <= pass_d;
      auto_transition <= auto_d;
      shutdown_min <= shut_d;
      pwm_force <= pwm_d;
      spread_spectrum_on <= misc_q[conv_regs_pkg::SPREAD_BIT] && !pfm_s;
      changeover_code <= voltage_select_pin_s ? roof_q[4:0] : floor_q[4:0];
      current_limit_disable <= limit_q[conv_regs_pkg::LIMIT_OFF_BIT];
      soft_start_low <= limit_q[conv_regs_pkg::SOFT_START_BIT];
      valley_limit_code <= limit_q[conv_regs_pkg::VALLEY_LSB +: 4];
    end
  end

  // Boost average limit held for the full window
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      avg_cnt_q <= '0;
    else if (!(avg_lim_s && boost_s))
      avg_cnt_q <= '0;
    else if (avg_cnt_q != BOOST_LAST)
      avg_cnt_q <= avg_cnt_q + 1'b1;
  end
  assign boost_limit_event = avg_lim_s && boost_s && (avg_cnt_q == BOOST_LAST);

  // Clear-on-read flags
  assign status_read = hit(reg_rd, reg_addr, conv_regs_pkg::ADDR_STATUS);
  assign fl.event_set[conv_regs_pkg::FL_THERMAL] = therm_s;
  assign fl.event_set[conv_regs_pkg::FL_BYPASS] = byp_lim_s;
  assign fl.event_set[conv_regs_pkg::FL_BOOST] = boost_limit_event;
  assign fl.event_set[conv_regs_pkg::FL_FAULT] = fault_event || therm_s || byp_lim_s
    || boost_limit_event;
  assign fl.clear_all = status_read;
  assign fl.wipe = soft_reset;
  flag_capture u_flags (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .fl(fl)
  );

  // Fault output, open drain, only in the reset/fault role
  assign fault_irq_pin_n_o = 1'b0;
  assign fault_irq_pin_n_oe = !misc_q[conv_regs_pkg::PIN_ROLE_BIT]
    && fl.flags[conv_regs_pkg::FL_FAULT];

  // Status word
  always_comb
  begin
    status_word = '0;
    status_word[conv_regs_pkg::ST_THERMAL] = fl.flags[conv_regs_pkg::FL_THERMAL];
    status_word[conv_regs_pkg::ST_HOT] = hot_s;
    status_word[conv_regs_pkg::ST_PFM] = pfm_s;
    status_word[conv_regs_pkg::ST_BOOST] = boost_s;
    status_word[conv_regs_pkg::ST_BYPASS_LIM] = fl.flags[conv_regs_pkg::FL_BYPASS];
    status_word[conv_regs_pkg::ST_BOOST_LIM] = fl.flags[conv_regs_pkg::FL_BOOST];
    status_word[conv_regs_pkg::ST_FAULT] = fl.flags[conv_regs_pkg::FL_FAULT];
    status_word[conv_regs_pkg::ST_RANGE] = ok_s || pass_through_force;
  end

  // Read data, one cycle after the address; unknown addresses read zero
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= conv_regs_pkg::READ_NONE;
    else
    begin
      case (reg_addr)
        conv_regs_pkg::ADDR_MISC: reg_rdata <= misc_q;
        conv_regs_pkg::ADDR_FLOOR: reg_rdata <= floor_q;
        conv_regs_pkg::ADDR_ROOF: reg_rdata <= roof_q;
        conv_regs_pkg::ADDR_LIMIT: reg_rdata <= limit_q;
        conv_regs_pkg::ADDR_STATUS: reg_rdata <= status_word;
        conv_regs_pkg::ADDR_NVM: reg_rdata <= nvm_q | {2'b00, nvm_locked_status, 5'b00000};
        default: reg_rdata <= conv_regs_pkg::READ_NONE;
      endcase
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  soft_reset_defaults_a: assert property (soft_reset |=> misc_q == MISC_DEFAULT
    && limit_q == conv_regs_pkg::LIMIT_RESET)
    else $error("soft reset did not restore defaults");
  power_cycle_off_a: assert property (soft_reset |=> ##1 !converter_on [*3])
    else $error("converter not cycled off after soft reset");
  shutdown_code_a: assert property ((misc_q[6:5] == 2'h3) |=> shutdown_min && !converter_on)
    else $error("shutdown code did not shut down");
  pass_force_a: assert property ((misc_q[6:5] == 2'h2 && power_q == ST_RUN)
    |=> pass_through_force && converter_on)
    else $error("pass-through not forced");
  reserved_zero_a: assert property (misc_q[conv_regs_pkg::MISC_RSVD_BIT] == 1'b0
    && floor_q[7:5] == 3'b000 && limit_q[7:6] == 2'b00)
    else $error("reserved bit holds data");
  read_set_wins_a: assert property ((status_read && therm_s && !soft_reset)
    |=> ##1 reg_rdata[conv_regs_pkg::ST_THERMAL] || reg_addr != conv_regs_pkg::ADDR_STATUS)
    else $error("thermal flag lost on clearing read");
  range_forced_a: assert property ((reg_addr == conv_regs_pkg::ADDR_STATUS
    && pass_through_force) |=> reg_rdata[conv_regs_pkg::ST_RANGE])
    else $error("range bit not forced in pass-through");
  nvm_self_clear_a: assert property ((nvm_write_done
    && !hit(reg_wr, reg_addr, conv_regs_pkg::ADDR_NVM) && !soft_reset) |=> !nvm_write_req)
    else $error("write enable not cleared after copy");
  threshold_pick_a: assert property ((!voltage_select_pin_s && $stable(floor_q))
    |=> changeover_code == $past(floor_q[4:0]))
    else $error("floor threshold not used with voltage_select_pin low");

  cover_soft_reset_c: cover property (soft_reset ##1 power_q == ST_OFF);
  cover_boost_limit_c: cover property (boost_limit_event);
  cover_status_read_c: cover property (status_read && fl.flags != '0);
endmodule

// ===== sim/nvm_store_model.sv
/*
  Behavioural non-volatile store facing the register bank.
  Assumes the core clock; answers a held write request after LATENCY cycles.
*/
`timescale 1ns/100ps
module nvm_store_model #(
  parameter int LATENCY = 6
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Copy handshake
  input wire logic nvm_write_req,
  output logic nvm_write_done
);
  int unsigned wait_q;

  // One done pulse, then another every LATENCY+1 cycles while the request stays high
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wait_q <= 0;
      nvm_write_done <= 1'b0;
    end
    else
    begin
      nvm_write_done <= nvm_write_req && (wait_q == LATENCY - 1);
      wait_q <= (nvm_write_req && !nvm_write_done && wait_q < LATENCY) ? wait_q + 1 : 0;
    end
  end
endmodule

// ===== sim/converter_config_status_regs_tb.sv
/*
  Self-checking bench for the converter register bank.
  Assumes the bank's strobe port and a store model answering copy requests.
*/
`timescale 1ns/100ps
module converter_config_status_regs_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic enable_pin = 1'b0;
  logic bypass_pin_n = 1'b1;
  logic voltage_select_pin = 1'b0;
  logic gpio_pin_i = 1'b0;
  logic thermal_trip = 1'b0;
  logic die_hot = 1'b0;
  logic pfm_state = 1'b0;
  logic boost_state = 1'b0;
  logic bypass_limit_hit = 1'b0;
  logic avg_limit_hit = 1'b0;
  logic output_ok = 1'b0;
  logic fault_event = 1'b0;
  logic nvm_locked_status = 1'b0;
  logic nvm_write_done, fault_irq_pin_n_oe, nvm_write_req, nvm_protect_req;
  logic fault_irq_pin_n_o;
  logic converter_on, pass_through_force, auto_transition, shutdown_min, pwm_force;
  logic spread_spectrum_on, current_limit_disable, soft_start_low;
  logic [4:0] changeover_code;
  logic [3:0] valley_limit_code;
  int bad_count = 0;
  int checks = 0;

  always #2 core_clk = ~core_clk;

  converter_config_status_regs #(.BOOST_LIMIT_CYCLES(20)) dut (
    .core_clk, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .enable_pin, .bypass_pin_n, .voltage_select_pin, .gpio_pin_i,
    .fault_irq_pin_n_o, .fault_irq_pin_n_oe,
    .thermal_trip, .die_hot, .pfm_state, .boost_state, .bypass_limit_hit,
    .avg_limit_hit, .output_ok, .fault_event,
    .nvm_write_done, .nvm_locked_status, .nvm_write_req, .nvm_protect_req,
    .converter_on, .pass_through_force, .auto_transition, .shutdown_min, .pwm_force,
    .spread_spectrum_on, .changeover_code, .current_limit_disable, .soft_start_low,
    .valley_limit_code
  );

  nvm_store_model partner (.core_clk, .rst_n, .nvm_write_req, .nvm_write_done);

  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
  endtask

  // Status reads also pulse the clearing strobe after the value is seen
  task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    reg_addr = a;
    tick(1);
    chk(reg_rdata & m, e);
    reg_rd = (a == conv_regs_pkg::ADDR_STATUS);
    tick(1);
    reg_rd = 1'b0;
  endtask

  task results;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  initial
  begin
    #50000;
    bad_count++;
    results;
  end

  initial
  begin
    tick(2);
    rst_n = 1'b1;
    tick(1);
    rd(8'h01, 8'hff, 8'h01);
    rd(8'h02, 8'hff, 8'h06);
    rd(8'h03, 8'hff, 8'h06);
    rd(8'h04, 8'hff, 8'h1b);
    rd(8'hff, 8'hff, 8'h00);
    rd(8'h00, 8'hff, 8'h00);
    enable_pin = 1'b1;
    bypass_pin_n = 1'b0;
    tick(4);
    chk(pass_through_force, 1'b1);
    chk(converter_on, 1'b1);
    bypass_pin_n = 1'b1;
    tick(4);
    chk(auto_transition, 1'b1);
    chk(shutdown_min, 1'b0);
    wr(8'h01, 8'h7f);
    rd(8'h01, 8'hff, 8'h6f);
    wr(8'h02, 8'hff);
    rd(8'h02, 8'hff, 8'h1f);
    wr(8'h03, 8'hff);
    rd(8'h03, 8'hff, 8'h1f);
    wr(8'h04, 8'hff);
    wr(8'h05, 8'hff);
    rd(8'h04, 8'hff, 8'h3f);
    rd(8'h05, 8'hff, 8'h00);
    chk(current_limit_disable, 1'b1);
    chk(soft_start_low, 1'b1);
    wr(8'h04, 8'h08);
    tick(1);
    chk(current_limit_disable, 1'b0);
    chk(soft_start_low, 1'b0);
    chk(valley_limit_code, 4'h8);
    for (int e = 1; e < 4; e++)
    begin
      wr(8'h01, {1'b0, e[1:0], 5'h01});
      tick(1);
      chk(auto_transition, e == 1);
      chk(pass_through_force, e == 2);
      chk(shutdown_min, e == 3);
      if (e != 2) chk(converter_on, e == 1);
      rd(8'h05, 8'h01, {7'h00, e == 2});
    end
    wr(8'h01, 8'h28);
    gpio_pin_i = 1'b1;
    tick(4);
    chk(pwm_force, 1'b1);
    gpio_pin_i = 1'b0;
    tick(4);
    chk(pwm_force, 1'b0);
    wr(8'h01, 8'h21);
    tick(1);
    chk(pwm_force, 1'b0);
    wr(8'h01, 8'h26);
    tick(1);
    chk(pwm_force, 1'b1);
    chk(spread_spectrum_on, 1'b1);
    pfm_state = 1'b1;
    boost_state = 1'b1;
    tick(4);
    chk(spread_spectrum_on, 1'b0);
    rd(8'h05, 8'h30, 8'h30);
    pfm_state = 1'b0;
    boost_state = 1'b0;
    wr(8'h01, 8'h23);
    wr(8'h02, 8'h00);
    tick(1);
    chk(pwm_force, 1'b0);
    chk(changeover_code, 5'h00);
    voltage_select_pin = 1'b1;
    tick(4);
    chk(pwm_force, 1'b1);
    chk(changeover_code, 5'h1f);
    voltage_select_pin = 1'b0;
    wr(8'h01, 8'h21);
    thermal_trip = 1'b1;
    tick(4);
    thermal_trip = 1'b0;
    tick(4);
    chk(fault_irq_pin_n_oe, 1'b1);
    chk(fault_irq_pin_n_o, 1'b0);
    rd(8'h05, 8'h8a, 8'h82);
    rd(8'h05, 8'h8a, 8'h00);
    chk(fault_irq_pin_n_oe, 1'b0);
    bypass_limit_hit = 1'b1;
    tick(4);
    rd(8'h05, 8'h0a, 8'h0a);
    rd(8'h05, 8'h08, 8'h08);
    bypass_limit_hit = 1'b0;
    tick(4);
    rd(8'h05, 8'h08, 8'h08);
    rd(8'h05, 8'h0a, 8'h00);
    boost_state = 1'b1;
    avg_limit_hit = 1'b1;
    tick(15);
    rd(8'h05, 8'h06, 8'h00);
    tick(15);
    rd(8'h05, 8'h06, 8'h06);
    avg_limit_hit = 1'b0;
    boost_state = 1'b0;
    die_hot = 1'b1;
    tick(4);
    rd(8'h05, 8'h40, 8'h40);
    die_hot = 1'b0;
    tick(4);
    rd(8'h05, 8'h40, 8'h00);
    wr(8'hff, 8'hff);
    tick(1);
    chk(nvm_write_req, 1'b1);
    chk(nvm_protect_req, 1'b1);
    tick(12);
    chk(nvm_write_req, 1'b0);
    nvm_locked_status = 1'b1;
    rd(8'hff, 8'hff, 8'h60);
    wr(8'h01, 8'h80);
    tick(5);
    chk(converter_on, 1'b0);
    chk(shutdown_min, 1'b1);
    rd(8'h03, 8'hff, 8'h06);
    rd(8'hff, 8'hff, 8'h20);
    tick(260);
    // Manual reset through the pin in its default role
    gpio_pin_i = 1'b1;
    tick(4);
    wr(8'h02, 8'h11);
    gpio_pin_i = 1'b0;
    tick(6);
    rd(8'h02, 8'hff, 8'h06);
    results;
  end
endmodule
